// [rtl/synth_ctl_map.vh]
// register offsets, field positions, reset values of the synthesizer control
// assumes byte addressing on a 32-bit AHB-Lite bus, one register per word
`ifndef SYNTH_CTL_MAP_VH
`define SYNTH_CTL_MAP_VH

// ***************************************
// register byte offsets
// ***************************************
`define STEP_CODE_OFS 8'h00
`define OFFSET_RANGE_OFS 8'h04
`define MODE_OFS 8'h08
`define DIVIDER_OFS 8'h0c
`define STATUS_OFS 8'h10

// ***************************************
// mode register fields
// ***************************************
`define DIVIDER_BYPASS_POS 0
`define MAIN_PRESCALE_SEL_LO_POS 1
`define MAIN_PRESCALE_SEL_HI_POS 2
`define REF_PRESCALE_SEL_LO_POS 3
`define REF_PRESCALE_SEL_HI_POS 4
`define REF_ENABLE_POS 5
`define REF_SELECT_POS 6
`define REF_POWERDOWN_POS 7
`define MAIN_POWERDOWN_POS 8
`define MODE_WIDTH 9

// ***************************************
// stored (power-up) values
// ***************************************
`define STEP_CODE_RESET 10'h1f4
`define OFFSET_RANGE_RESET 5'h0c
`define MODE_RESET 9'h060
`define DIVIDER_RESET 10'h000

`endif

// [rtl/synth_ctl.v]
// control logic of a dual-output clock synthesizer with AHB-Lite settings port
// assumes CLOCK stands for the master clock; the step code and offset range
// drive the analog oscillator; pins and enables are two-signal tri-states
//
// Design decisions made here: the address map and register access over AHB-Lite.
`include "synth_ctl_map.vh"
`timescale 1ns/1ps
`default_nettype none

module synth_ctl (
    // clock, reset, enable
    input wire CLOCK,
    input wire RESET,
    input wire CE,
    // ahb-lite slave
    input wire HSEL,
    input wire [7:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output wire HREADYOUT,
    output wire HRESP,
    output reg [31:0] HRDATA,
    // control pins
    input wire REF_CONTROL_PIN,
    input wire MAIN_CONTROL_PIN,
    // clock outputs, enable low while driving
    output wire REF_CLOCK_OUT,
    output wire REF_CLOCK_OUT_OE_N,
    output wire MAIN_CLOCK_OUT,
    output wire MAIN_CLOCK_OUT_OE_N,
    // oscillator control
    output wire [9:0] STEP_CODE,
    output wire [4:0] OFFSET_RANGE,
    output reg OSC_RUN
);

    // ***************************************
    // settings registers
    // ***************************************
    reg [9:0] step_code;
    reg [4:0] offset_range;
    reg [`MODE_WIDTH-1:0] mode;
    reg [9:0] divider;
    reg wr_pend;
    reg [7:0] wr_addr;
    wire addr_phase;
    wire [11:0] status;

    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign STEP_CODE = step_code;
    assign OFFSET_RANGE = offset_range;
    assign addr_phase = HSEL & HTRANS[1] & HREADY;

    // bus slave: write in data phase, read data registered at address phase
    always @(posedge CLOCK) begin
        if (RESET) begin
            step_code <= `STEP_CODE_RESET;
            offset_range <= `OFFSET_RANGE_RESET;
            mode <= `MODE_RESET;
            divider <= `DIVIDER_RESET;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            HRDATA <= 32'h00000000;
        end else if (CE) begin
            wr_pend <= addr_phase & HWRITE;
            wr_addr <= HADDR;
            if (wr_pend) begin
                // any write takes effect at once, even while running
                if (wr_addr == `STEP_CODE_OFS) begin
                    step_code <= HWDATA[9:0];
                end else if (wr_addr == `OFFSET_RANGE_OFS) begin
                    offset_range <= HWDATA[4:0];
                end else if (wr_addr == `MODE_OFS) begin
                    mode <= HWDATA[`MODE_WIDTH-1:0];
                end else if (wr_addr == `DIVIDER_OFS) begin
                    divider <= HWDATA[9:0];
                end
            end
            if (addr_phase & ~HWRITE) begin
                if (HADDR == `STEP_CODE_OFS) begin
                    HRDATA <= {22'h000000, step_code};
                end else if (HADDR == `OFFSET_RANGE_OFS) begin
                    HRDATA <= {27'h0000000, offset_range};
                end else if (HADDR == `MODE_OFS) begin
                    HRDATA <= {23'h000000, mode};
                end else if (HADDR == `DIVIDER_OFS) begin
                    HRDATA <= {22'h000000, divider};
                end else if (HADDR == `STATUS_OFS) begin
                    HRDATA <= {20'h00000, status};
                end else begin
                    HRDATA <= 32'h00000000; // unmapped reads zero
                end
            end
        end
    end

    // ***************************************
    // control pin synchronisers
    // ***************************************
    reg [1:0] pin_meta;
    reg [1:0] pin_sync;

    // two flops before any logic sees a pin
    always @(posedge CLOCK) begin
        if (RESET) begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
        end else if (CE) begin
            pin_meta <= {MAIN_CONTROL_PIN, REF_CONTROL_PIN};
            pin_sync <= pin_meta;
        end
    end

    // ***************************************
    // control pin role decode
    // ***************************************
    wire ref_pin;
    wire main_pin;
    wire ref_enable_bit;
    wire ref_select_bit;
    wire ref_powerdown_bit;
    wire main_powerdown_bit;
    wire ref_all_clear;
    wire shutdown;
    wire ref_want;
    wire main_want;
    wire ref_prescaled;

    assign ref_pin = pin_sync[0];
    assign main_pin = pin_sync[1];
    assign ref_enable_bit = mode[`REF_ENABLE_POS];
    assign ref_select_bit = mode[`REF_SELECT_POS];
    assign ref_powerdown_bit = mode[`REF_POWERDOWN_POS];
    assign main_powerdown_bit = mode[`MAIN_POWERDOWN_POS];
    assign ref_all_clear = ~ref_enable_bit & ~ref_select_bit & ~ref_powerdown_bit;

    // either pin may shut down the device
    assign shutdown = (ref_powerdown_bit & ref_pin)
        | (main_powerdown_bit & main_pin)
        | (ref_all_clear & ref_pin);

    // reference drive: off when all bits clear, pin high disables in enable mode
    assign ref_want = ~shutdown & ~ref_all_clear
        & ~(ref_enable_bit & ~ref_powerdown_bit & ref_pin);

    // main pin low drives in both modes
    assign main_want = ~shutdown & ~main_pin;

    // reference mux select: pin in mux mode, select bit otherwise
    assign ref_prescaled = (ref_enable_bit | ref_powerdown_bit) ? ref_select_bit
        : ref_pin;

    // ***************************************
    // per-output prescaler, divider on the main output only
    // ***************************************
    wire [1:0] want;
    wire [2:0] mask [0:1];
    wire [1:0] bypass;
    wire [11:0] half_point;
    wire [1:0] chan_out;
    wire [1:0] chan_active;

    assign want = {main_want, ref_want};
    // select code to divisor minus one: 1, 2, 4, 8
    assign mask[0] = ref_prescaled ?
        ((3'h1 << {mode[`REF_PRESCALE_SEL_HI_POS], mode[`REF_PRESCALE_SEL_LO_POS]}) - 3'h1)
        : 3'h0;
    assign mask[1] = (3'h1 << {mode[`MAIN_PRESCALE_SEL_HI_POS], mode[`MAIN_PRESCALE_SEL_LO_POS]}) - 3'h1;
    assign bypass = {mode[`DIVIDER_BYPASS_POS], 1'b1};
    assign half_point = {2'h0, divider} + 12'h002;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : chan
            reg [2:0] pcnt;
            reg [11:0] dcnt;
            reg out;
            reg active;
            wire tick;

            // every output edge lands on a master clock edge
            // a prescale change that leaves the count above the new end still wraps at once
            assign tick = (pcnt >= mask[ch]);
            assign chan_out[ch] = out;
            assign chan_active[ch] = active;

            // counting starts from zero on each enable, so delay is fixed
            always @(posedge CLOCK) begin
                if (RESET) begin
                    pcnt <= 3'h0;
                    dcnt <= 12'h000;
                    out <= 1'b0;
                    active <= 1'b0;
                end else if (CE) begin
                    if (!active) begin
                        pcnt <= 3'h0;
                        dcnt <= 12'h000;
                        out <= 1'b0;
                        active <= want[ch];
                    end else begin
                        // drop the drive only while the output is low
                        if (!want[ch] && !out) begin
                            active <= 1'b0;
                        end
                        pcnt <= tick ? 3'h0 : pcnt + 3'h1;
                        if (tick) begin
                            if (bypass[ch]) begin
                                out <= ~out;
                                dcnt <= 12'h000;
                            end else begin
                                // two edges per divided period, 50% duty
                                if (dcnt == 12'h000 || dcnt == half_point) begin
                                    out <= ~out;
                                end
                                // a smaller divider written while running wraps at once
                                if (dcnt >= {half_point[10:0], 1'b0} - 12'h001) begin
                                    dcnt <= 12'h000;
                                end else begin
                                    dcnt <= dcnt + 12'h001;
                                end
                            end
                        end
                    end
                end
            end
        end
    endgenerate

    // ***************************************
    // outputs and oscillator run
    // ***************************************
    assign REF_CLOCK_OUT = chan_out[0];
    assign REF_CLOCK_OUT_OE_N = ~chan_active[0];
    assign MAIN_CLOCK_OUT = chan_out[1];
    assign MAIN_CLOCK_OUT_OE_N = ~chan_active[1];
    assign status = {5'h00, shutdown, main_pin, ref_pin, ref_prescaled, chan_active, OSC_RUN};

    // oscillator stops once shutdown and both outputs have gone quiet
    always @(posedge CLOCK) begin
        if (RESET) begin
            OSC_RUN <= 1'b1;
        end else if (CE) begin
            OSC_RUN <= ~(shutdown & ~chan_active[0] & ~chan_active[1]);
        end
    end

endmodule

`default_nettype wire

// [sim/synth_ctl_monitor.sv]
// assertions on the synthesizer control ports
// assumes binding to synth_ctl, include path holding rtl
`include "synth_ctl_map.vh"
`timescale 1ns/1ps
`default_nettype none
module synth_ctl_monitor (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESET,
    // bus
    input wire logic HSEL,
    input wire logic [7:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [31:0] HRDATA,
    // pins and settings
    input wire logic MAIN_CONTROL_PIN,
    input wire logic REF_CLOCK_OUT,
    input wire logic REF_CLOCK_OUT_OE_N,
    input wire logic MAIN_CLOCK_OUT,
    input wire logic MAIN_CLOCK_OUT_OE_N,
    input wire logic [9:0] STEP_CODE,
    input wire logic [4:0] OFFSET_RANGE,
    input wire logic OSC_RUN
);
    // ****
    // checks
    // ****
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RESET);
    wire req = HSEL && HTRANS[1] && HREADY;
    int hold_cnt = 0;
    // cycles the main pin is high while the output still drives
    always @(posedge CLOCK) begin
        if (RESET || !MAIN_CONTROL_PIN || MAIN_CLOCK_OUT_OE_N) hold_cnt <= 0;
        else hold_cnt <= hold_cnt + 1;
    end
    property p_ready; HREADYOUT && !HRESP; endproperty
    a_ready: assert property (p_ready) else $error("bus stalled or error");
    property p_step; req && HWRITE && HADDR == `STEP_CODE_OFS |-> ##2 STEP_CODE == $past(HWDATA[9:0]); endproperty
    a_step: assert property (p_step) else $error("step code not updated");
    property p_offset; req && HWRITE && HADDR == `OFFSET_RANGE_OFS |-> ##2 OFFSET_RANGE == $past(HWDATA[4:0]); endproperty
    a_offset: assert property (p_offset) else $error("offset not updated");
    property p_unmapped; req && !HWRITE && HADDR == 8'h14 |=> HRDATA == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_down; !OSC_RUN |-> REF_CLOCK_OUT_OE_N && MAIN_CLOCK_OUT_OE_N; endproperty
    a_down: assert property (p_down) else $error("output driven in shutdown");
    property p_main_drain; $rose(MAIN_CLOCK_OUT_OE_N) |-> !$past(MAIN_CLOCK_OUT); endproperty
    a_main_drain: assert property (p_main_drain) else $error("main cut while high");
    property p_ref_drain; $rose(REF_CLOCK_OUT_OE_N) |-> !$past(REF_CLOCK_OUT); endproperty
    a_ref_drain: assert property (p_ref_drain) else $error("ref cut while high");
    property p_main_off; hold_cnt < 8300; endproperty
    a_main_off: assert property (p_main_off) else $error("main not released");
    c_shut: cover property ($fell(OSC_RUN));
    c_main_on: cover property ($fell(MAIN_CLOCK_OUT_OE_N));
    c_ref_on: cover property ($fell(REF_CLOCK_OUT_OE_N));
endmodule
`default_nettype wire

// [sim/ahb_host.sv]
// ahb-lite host standing for the settings master
// assumes one slave whose hreadyout is the bus hready
`timescale 1ns/1ps
`default_nettype none
module ahb_host (
    // clock and answer
    input wire logic clock,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // request
    output logic hsel = 1'b0,
    output logic [7:0] haddr = 8'h00,
    output logic [1:0] htrans = 2'b00,
    output logic hwrite = 1'b0,
    output logic [2:0] hsize = 3'b010,
    output logic [31:0] hwdata = 32'h0
);
    // single word transfer, released lines carry inverse values
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge clock); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        haddr <= ~a;
        hwdata <= w ? d : ~d;
        do @(posedge clock); while (hready !== 1'b1);
        r = hrdata;
        hwdata <= ~hwdata;
    endtask
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench of synth_ctl with a behavioural output model
// assumes the map header on the include path
`include "synth_ctl_map.vh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin err_total++; \
    $display("ERROR %0t: got %0h exp %0h", $time, g, x); end end
module tb_top;
    logic CLOCK = 0, RESET = 1, rp = 0, mp = 0, hsel, hwrite;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd, d, seed = 32'h5689;
    wire hready, hresp, r_out, r_oe_n, m_out, m_oe_n, osc;
    wire [9:0] step;
    wire [4:0] ofs;
    int err_total = 0, comparisons = 0, cyc = 0;
    // ****
    // structure
    // ****
    synth_ctl u_synth_ctl(.CLOCK(CLOCK), .RESET(RESET), .CE(1'b1), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready), .HRESP(hresp),
        .HRDATA(hrdata), .REF_CONTROL_PIN(rp), .MAIN_CONTROL_PIN(mp), .REF_CLOCK_OUT(r_out),
        .REF_CLOCK_OUT_OE_N(r_oe_n), .MAIN_CLOCK_OUT(m_out), .MAIN_CLOCK_OUT_OE_N(m_oe_n), .STEP_CODE(step),
        .OFFSET_RANGE(ofs), .OSC_RUN(osc));
    ahb_host u_ahb_host(.clock(CLOCK), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    // clock and timeout
    initial forever #5 CLOCK = ~CLOCK;
    always @(posedge CLOCK) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            results();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        u_ahb_host.xfer(1'b1, a, v, rd);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        u_ahb_host.xfer(1'b0, a, 32'h0, rd);
        `CHK(rd, e)
    endtask
    // e is the expected toggle spacing, 0 for high impedance
    task automatic meas(input bit m, input int e);
        int t, n;
        logic v;
        t = 0;
        while ((m ? m_oe_n : r_oe_n) !== (e == 0) && t < 9000) begin
            @(negedge CLOCK);
            t++;
        end
        if (e == 0) `CHK(m ? m_oe_n : r_oe_n, 1'b1)
        else begin
            for (int k = 0; k < 3; k++) begin
                v = m ? m_out : r_out;
                n = 0;
                while ((m ? m_out : r_out) === v && n < 9000) begin
                    @(negedge CLOCK);
                    n++;
                end
            end
            `CHK(n, e)
        end
    endtask
    // reference model of pins, mode and divider
    task automatic run(input logic [8:0] md, input logic [9:0] dv, input logic p0, input logic p1);
        int m0, m1, t;
        logic sd, ron, rsel;
        m0 = 1 << {md[4], md[3]};
        m1 = 1 << {md[2], md[1]};
        sd = (md[7] && p0) || (!md[5] && !md[6] && !md[7] && p0) || (md[8] && p1);
        ron = !sd && ((md[7] || md[5]) ? !p0 : md[6]);
        rsel = (md[5] || md[7]) ? md[6] : p0;
        wr(`DIVIDER_OFS, {22'h0, dv});
        wr(`MODE_OFS, {23'h0, md});
        rp <= p0;
        mp <= p1;
        meas(0, ron ? (rsel ? m0 : 1) : 0);
        meas(1, (!sd && !p1) ? (md[0] ? m1 : (dv + 2) * m1) : 0);
        t = 0;
        while (osc !== !sd && t < 9000) begin
            @(negedge CLOCK);
            t++;
        end
        `CHK(osc, !sd)
    endtask
    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ****
    // scenarios
    // ****
    initial begin
        repeat (10) @(posedge CLOCK);
        RESET <= 1'b0;
        rdchk(`STEP_CODE_OFS, 32'h1f4);
        rdchk(`OFFSET_RANGE_OFS, 32'h0c);
        rdchk(`MODE_OFS, 32'h060);
        rdchk(`DIVIDER_OFS, 32'h0);
        wr(8'h14, rnd());
        rdchk(8'h14, 32'h0);
        for (int i = 0; i < 3; i++) begin
            d = rnd();
            wr(`STEP_CODE_OFS, d);
            rdchk(`STEP_CODE_OFS, d & 32'h3ff);
            wr(`OFFSET_RANGE_OFS, d >> 10);
            rdchk(`OFFSET_RANGE_OFS, (d >> 10) & 32'h1f);
        end
        for (int i = 0; i < 4; i++) run(9'(97 + i * 10), 10'h0, 0, 0);
        for (int i = 0; i < 3; i++) run(9'h062, 10'(rnd() % 6), 0, 0);
        run(9'h020, 10'h3, 0, 0);
        run(9'h060, 10'h0, 1, 0);
        run(9'h050, 10'h0, 1, 0);
        run(9'h050, 10'h0, 0, 0);
        run(9'h0f0, 10'h0, 1, 0);
        run(9'h0f0, 10'h0, 0, 0);
        run(9'h000, 10'h0, 1, 0);
        run(9'h000, 10'h0, 0, 0);
        run(9'h060, 10'h0, 0, 1);
        run(9'h160, 10'h0, 0, 1);
        run(9'h1e0, 10'h0, 1, 0);
        run(9'h160, 10'h1, 0, 0);
        results();
    end
endmodule
bind synth_ctl synth_ctl_monitor u_synth_ctl_monitor(.CLOCK(CLOCK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .HRDATA(HRDATA), .MAIN_CONTROL_PIN(MAIN_CONTROL_PIN), .REF_CLOCK_OUT(REF_CLOCK_OUT),
    .REF_CLOCK_OUT_OE_N(REF_CLOCK_OUT_OE_N), .MAIN_CLOCK_OUT(MAIN_CLOCK_OUT),
    .MAIN_CLOCK_OUT_OE_N(MAIN_CLOCK_OUT_OE_N), .STEP_CODE(STEP_CODE), .OFFSET_RANGE(OFFSET_RANGE), .OSC_RUN(OSC_RUN));
`default_nettype wire
